// [rtl/uep0_cfg.svh]
// address map, field positions and reset values of the ep0/status block
// assumes a 32-bit ahb-lite slave, one register per aligned word
`ifndef UEP0_CFG_SVH
`define UEP0_CFG_SVH
`define UEP0_OFS_IN_CNT 8'h00
`define UEP0_OFS_OUT_CFG 8'h04
`define UEP0_OFS_OUT_CNT 8'h08
`define UEP0_OFS_FUNC_ADDR 8'h0c
`define UEP0_OFS_EVT_STATUS 8'h10
`define UEP0_OFS_EVT_MASK 8'h14
`define UEP0_NAK_BIT 7
`define UEP0_IRQEN_BIT 2
`define UEP0_STALL_BIT 3
`define UEP0_TOGGLE_BIT 5
`define UEP0_BME_BIT 7
`define UEP0_EVT_SETUP_OVERWRITE_FLAG 0
`define UEP0_EVT_WAKE 1
`define UEP0_EVT_SETUP 2
`define UEP0_EVT_RING1 3
`define UEP0_EVT_RING2 4
`define UEP0_EVT_RESUME 5
`define UEP0_EVT_SUSPEND 6
`define UEP0_EVT_PRST 7
`define UEP0_MAX_COUNT 4'h8
`define UEP0_IN_NAK_RST 1'b1
`define UEP0_OUT_NAK_RST 1'b1
`endif

// [rtl/uep0_pkg.sv]
// types shared by the ep0/status block
// assumes uep0_cfg.svh holds the numeric constants
package uep0_pkg;
  typedef enum logic [1:0] {
    UEP0_HS_NONE = 2'b00,
    UEP0_HS_ACK = 2'b01,
    UEP0_HS_NAK = 2'b10,
    UEP0_HS_STALL = 2'b11
  } uep0_hs_e;

  typedef struct packed {
    logic [3:0] in_cnt;
    logic in_nak;
    logic out_irq_en;
    logic out_stall;
    logic out_toggle;
    logic out_bme;
    logic [3:0] out_cnt;
    logic out_nak;
    logic [6:0] func_addr;
    logic [7:0] evt_status;
    logic [7:0] evt_mask;
    logic [7:0] bus_addr;
    logic bus_wr;
    logic bus_rd;
    logic [31:0] hrdata;
    logic irq;
    logic xfer_irq;
    uep0_hs_e in_hs;
    uep0_hs_e out_hs;
    logic [3:0] in_len;
    logic bm_out_en;
  } uep0_state_s;
endpackage

// [rtl/uep0_regs.sv]
// endpoint-0 descriptor registers and usb event status/mask, ahb-lite slave
// assumes synchronous event pulses from the usb engine; zero-wait slave
`timescale 1ns/1ps
`include "uep0_cfg.svh"
module uep0_regs
  import uep0_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic usb_func_reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic in_token,
  input wire logic in_done,
  input wire logic out_token,
  input wire logic out_done,
  input wire logic [3:0] out_rx_count,
  input wire logic out_rx_pid_data1,
  input wire logic setup_rx,
  input wire logic setup_buf_full,
  input wire logic remote_wake_flag_pin,
  input wire logic ring1_det,
  input wire logic ring2_det,
  input wire logic resume_det,
  input wire logic suspend_det,
  input wire logic port_reset_det,
  output logic [1:0] in_handshake,
  output logic [1:0] out_handshake,
  output logic [3:0] in_tx_length,
  output logic buffer_manager_out_en,
  output logic [6:0] assigned_bus_address,
  output logic xfer_done_irq,
  output logic usb_event_irq
);

  uep0_state_s s_ff;
  uep0_state_s nxt_s;

  function automatic logic [3:0] clip_count(input logic [3:0] c);
    clip_count = (c > `UEP0_MAX_COUNT) ? `UEP0_MAX_COUNT : c;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [7:0] hw_set;
  logic [7:0] sw_clr;
  logic wr_en;

  always_comb begin
    nxt_s = s_ff;
    hw_set = 8'h00;
    sw_clr = 8'h00;
    wr_en = s_ff.bus_wr;
    nxt_s.bus_wr = hsel && hready && htrans[1] && hwrite;
    nxt_s.bus_rd = hsel && hready && htrans[1] && !hwrite;
    if (hsel && hready && htrans[1]) begin
      nxt_s.bus_addr = haddr[7:0];
    end

    // event capture
    hw_set[`UEP0_EVT_SETUP_OVERWRITE_FLAG] = setup_rx && setup_buf_full;
    hw_set[`UEP0_EVT_WAKE] = remote_wake_flag_pin;
    hw_set[`UEP0_EVT_SETUP] = setup_rx;
    hw_set[`UEP0_EVT_RING1] = ring1_det;
    hw_set[`UEP0_EVT_RING2] = ring2_det;
    hw_set[`UEP0_EVT_RESUME] = resume_det;
    hw_set[`UEP0_EVT_SUSPEND] = suspend_det;
    hw_set[`UEP0_EVT_PRST] = port_reset_det;

    // register writes land in the data phase
    if (wr_en) begin
      if (hit(s_ff.bus_addr, `UEP0_OFS_IN_CNT)) begin
        nxt_s.in_cnt = hwdata[3:0];
        nxt_s.in_nak = hwdata[`UEP0_NAK_BIT];
      end
      if (hit(s_ff.bus_addr, `UEP0_OFS_OUT_CFG)) begin
        nxt_s.out_irq_en = hwdata[`UEP0_IRQEN_BIT];
        nxt_s.out_stall = hwdata[`UEP0_STALL_BIT];
        nxt_s.out_bme = hwdata[`UEP0_BME_BIT];
      end
      if (hit(s_ff.bus_addr, `UEP0_OFS_OUT_CNT)) begin
        nxt_s.out_nak = hwdata[`UEP0_NAK_BIT];
      end
      if (hit(s_ff.bus_addr, `UEP0_OFS_FUNC_ADDR)) begin
        nxt_s.func_addr = hwdata[6:0];
      end
      if (hit(s_ff.bus_addr, `UEP0_OFS_EVT_STATUS)) begin
        sw_clr = hwdata[7:0];
      end
      if (hit(s_ff.bus_addr, `UEP0_OFS_EVT_MASK)) begin
        nxt_s.evt_mask = hwdata[7:0];
      end
    end
    // set wins over clear so no event is lost
    nxt_s.evt_status = (s_ff.evt_status & ~sw_clr) | hw_set;

    // in pipe handshakes
    nxt_s.in_hs = UEP0_HS_NONE;
    if (in_token) begin
      if (s_ff.evt_status[`UEP0_EVT_SETUP] || s_ff.in_nak) begin
        nxt_s.in_hs = UEP0_HS_NAK;
      end else begin
        nxt_s.in_hs = UEP0_HS_ACK;
      end
    end
    if (in_done) begin
      nxt_s.in_nak = 1'b1;
    end
    nxt_s.in_len = clip_count(s_ff.in_cnt);

    // out pipe handshakes; stall takes precedence over nak
    nxt_s.out_hs = UEP0_HS_NONE;
    if (out_token) begin
      if (s_ff.out_stall) begin
        nxt_s.out_hs = UEP0_HS_STALL;
        nxt_s.out_stall = 1'b0;
      end else if (s_ff.evt_status[`UEP0_EVT_SETUP] || s_ff.out_nak) begin
        nxt_s.out_hs = UEP0_HS_NAK;
      end else begin
        nxt_s.out_hs = UEP0_HS_ACK;
      end
    end
    nxt_s.xfer_irq = 1'b0;
    if (out_done && !s_ff.out_nak && !s_ff.evt_status[`UEP0_EVT_SETUP]) begin
      nxt_s.out_cnt = clip_count(out_rx_count);
      nxt_s.out_nak = 1'b1;
      nxt_s.out_toggle = out_rx_pid_data1;
      nxt_s.xfer_irq = s_ff.out_irq_en;
    end
    nxt_s.bm_out_en = s_ff.out_bme && !s_ff.out_nak;
    nxt_s.irq = |(s_ff.evt_status & s_ff.evt_mask);

    // usb function reset restores reset values except the port reset flag and its mask bit
    if (usb_func_reset) begin
      nxt_s.in_cnt = 4'h0;
      nxt_s.in_nak = `UEP0_IN_NAK_RST;
      nxt_s.out_irq_en = 1'b0;
      nxt_s.out_stall = 1'b0;
      nxt_s.out_toggle = 1'b0;
      nxt_s.out_bme = 1'b0;
      nxt_s.out_cnt = 4'h0;
      nxt_s.out_nak = `UEP0_OUT_NAK_RST;
      nxt_s.func_addr = 7'h00;
      nxt_s.evt_mask[6:0] = 7'h00;
      nxt_s.evt_status[6:0] = hw_set[6:0];
    end

    // read data for the next data phase
    nxt_s.hrdata = 32'h0000_0000;
    if (nxt_s.bus_rd) begin
      case (haddr[7:0])
        `UEP0_OFS_IN_CNT: nxt_s.hrdata[7:0] = {s_ff.in_nak, 3'h0, s_ff.in_cnt};
        `UEP0_OFS_OUT_CFG: begin
          nxt_s.hrdata[7:0] = {s_ff.out_bme, 1'b0, s_ff.out_toggle, 1'b0,
                               s_ff.out_stall, s_ff.out_irq_en, 2'h0};
        end
        `UEP0_OFS_OUT_CNT: begin
          nxt_s.hrdata[7:0] = {s_ff.out_nak, 3'h0, s_ff.out_cnt};
        end
        `UEP0_OFS_FUNC_ADDR: nxt_s.hrdata[7:0] = {1'b0, s_ff.func_addr};
        `UEP0_OFS_EVT_STATUS: nxt_s.hrdata[7:0] = s_ff.evt_status;
        `UEP0_OFS_EVT_MASK: nxt_s.hrdata[7:0] = s_ff.evt_mask;
        default: nxt_s.hrdata = 32'h0000_0000;
      endcase
    end
  end

  // async reset loads constants only; port reset flag survives function reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff <= '0;
      s_ff.in_nak <= `UEP0_IN_NAK_RST;
      s_ff.out_nak <= `UEP0_OUT_NAK_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_ff.hrdata;
  assign in_handshake = s_ff.in_hs;
  assign out_handshake = s_ff.out_hs;
  assign in_tx_length = s_ff.in_len;
  assign buffer_manager_out_en = s_ff.bm_out_en;
  assign assigned_bus_address = s_ff.func_addr;
  assign xfer_done_irq = s_ff.xfer_irq;
  assign usb_event_irq = s_ff.irq;

endmodule

// [tb/uep0_host.sv]
// usb engine side model: tokens, data completions and setup packets
// assumes the bench calls its tasks from one process only
`timescale 1ns/1ps
module uep0_host (
  input wire logic hclk,
  input wire logic [1:0] in_handshake,
  input wire logic [1:0] out_handshake,
  output logic in_token = 1'b0,
  output logic in_done = 1'b0,
  output logic out_token = 1'b0,
  output logic out_done = 1'b0,
  output logic [3:0] out_rx_count = 4'h0,
  output logic out_rx_pid_data1 = 1'b0,
  output logic setup_rx = 1'b0
);
  task automatic tok(input logic o, su, output logic [1:0] hs);
    @(posedge hclk);
    if (su) begin
      setup_rx <= 1'b1;
      @(posedge hclk);
      setup_rx <= 1'b0;
    end
    in_token <= !o;
    out_token <= o;
    @(posedge hclk);
    in_token <= 1'b0;
    out_token <= 1'b0;
    #1 hs = o ? out_handshake : in_handshake;
  endtask
  // data is only sent after the bench saw an ack
  task automatic dn(input logic o, input logic [3:0] n, input logic p);
    @(posedge hclk);
    in_done <= !o;
    out_done <= o;
    out_rx_count <= n;
    out_rx_pid_data1 <= p;
    @(posedge hclk);
    in_done <= 1'b0;
    out_done <= 1'b0;
  endtask
endmodule

// [tb/uep0_sva.sv]
// checker: handshake, clipping and bus invariants of uep0_regs
// assumes it is bound to every uep0_regs instance
`timescale 1ns/1ps
module uep0_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic in_token,
  input wire logic out_token,
  input wire logic out_done,
  input wire logic setup_rx,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [1:0] in_handshake,
  input wire logic [1:0] out_handshake,
  input wire logic [3:0] in_tx_length,
  input wire logic xfer_done_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_setup_in;
    setup_rx ##1 in_token;
  endsequence
  sequence s_setup_out;
    setup_rx ##1 out_token;
  endsequence
  a_len_clip:
    assert property (in_tx_length <= 4'h8) else $error("length above 8");
  a_setup_in_nak:
    assert property (s_setup_in |=> in_handshake == 2'h2)
    else $error("in not nak after setup");
  a_setup_out_nak:
    assert property (s_setup_out |=> out_handshake[1])
    else $error("out acked after setup");
  a_in_hs_idle:
    assert property (!in_token |=> in_handshake == 2'h0)
    else $error("in handshake without token");
  a_out_hs_idle:
    assert property (!out_token |=> out_handshake == 2'h0)
    else $error("out handshake without token");
  a_xfer_irq_cause:
    assert property (xfer_done_irq |-> $past(out_done))
    else $error("transfer irq without out done");
  a_bus_okay_resp:
    assert property (hreadyout && !hresp) else $error("bus not okay");
  a_rdata_upper:
    assert property (hrdata[31:8] == 24'h0) else $error("upper data set");
endmodule
bind uep0_regs uep0_sva chk (.*);

// [tb/usb_ep0_and_status_regs_test.sv]
// bench of uep0_regs: ahb-lite master, engine model, event pulses
// assumes zero-wait slave; expectations are constants or built from the stimulus (c, i, m), plus the bench clip function for lengths
`timescale 1ns/1ps
module usb_ep0_and_status_regs_test;
  logic hclk = 0, hresetn = 0, usb_func_reset = 0, hsel = 0, hwrite = 0;
  logic setup_buf_full = 0;
  logic [31:0] haddr = 0, hwdata = 0, q, rd_q;
  logic [1:0] htrans = 0, hs;
  logic [7:0] ev = 0, m = 8'haa;
  logic [3:0] c;
  wire logic hreadyout, hresp, in_token, in_done, out_token, out_done;
  wire logic out_rx_pid_data1, setup_rx, buffer_manager_out_en;
  wire logic xfer_done_irq, usb_event_irq;
  wire logic [31:0] hrdata;
  wire logic [1:0] in_handshake, out_handshake;
  wire logic [3:0] out_rx_count, in_tx_length;
  wire logic [6:0] assigned_bus_address;
  int errors = 0, cmp_count = 0, seed = 60, cyc = 0;
  uep0_regs DUT (.*, .hready(hreadyout), .hsize(3'h2), .remote_wake_flag_pin(ev[1]),
    .ring1_det(ev[3]), .ring2_det(ev[4]), .resume_det(ev[5]),
    .suspend_det(ev[6]), .port_reset_det(ev[7]));
  uep0_host host (.*);
  initial forever #4 hclk = ~hclk;
  // read data is taken at the edge that ends the data phase, free of races
  always @(posedge hclk) rd_q <= hrdata;
  function automatic logic [3:0] clip(input logic [3:0] v);
    return v > 4'h8 ? 4'h8 : v;
  endfunction
  task chk(input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    #1 q = rd_q;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task complete_run;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under 20000 cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h00, 32'h80);
    rd(8'h04, 32'h00);
    rd(8'h08, 32'h80);
    rd(8'h18, 32'h00);
    for (int i = 0; i < 6; i++) begin
      c = (i == 0) ? 4'hf : 4'($random(seed));
      bus(1'b1, 8'h00, {28'h0, c});
      @(posedge hclk);
      #1 chk(in_tx_length, clip(c));
      host.tok(1'b0, 1'b0, hs);
      chk(hs, 2'h1);
      host.dn(1'b0, 4'h0, 1'b0);
      host.tok(1'b0, 1'b0, hs);
      chk(hs, 2'h2);
    end
    host.tok(1'b1, 1'b0, hs);
    chk(hs, 2'h2);
    bus(1'b1, 8'h04, 32'h84);
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 4'h8 : 4'(unsigned'($random(seed)) % 9);
      bus(1'b1, 8'h08, 32'h0f);
      @(posedge hclk);
      #1 chk(buffer_manager_out_en, 1'b1);
      host.tok(1'b1, 1'b0, hs);
      chk(hs, 2'h1);
      host.dn(1'b1, c, i[0]);
      #1 chk(xfer_done_irq, 1'b1);
      rd(8'h08, {24'h0, 4'h8, c});
      rd(8'h04, {24'h0, 2'h2, i[0], 5'h4});
      host.tok(1'b1, 1'b0, hs);
      chk(hs, 2'h2);
    end
    bus(1'b1, 8'h04, 32'h08);
    bus(1'b1, 8'h08, 32'h00);
    host.tok(1'b1, 1'b0, hs);
    chk(hs, 2'h3);
    rd(8'h04, 32'h20);
    bus(1'b1, 8'h00, 32'h00);
    host.tok(1'b0, 1'b1, hs);
    chk(hs, 2'h2);
    setup_buf_full <= 1'b1;
    host.tok(1'b1, 1'b1, hs);
    chk(hs, 2'h2);
    rd(8'h10, 32'h05);
    bus(1'b1, 8'h10, 32'h00);
    rd(8'h10, 32'h05);
    bus(1'b1, 8'h10, 32'hff);
    rd(8'h10, 32'h00);
    bus(1'b1, 8'h14, {24'h0, m});
    for (int i = 1; i < 8; i++) if (i != 2) begin
      @(posedge hclk);
      ev[i] <= 1'b1;
      @(posedge hclk);
      ev[i] <= 1'b0;
      @(posedge hclk);
      #1 chk(usb_event_irq, m[i]);
      rd(8'h10, 32'h1 << i);
      bus(1'b1, 8'h10, 32'h1 << i);
    end
    // wake event lands on the same edge as its write-one clear
    fork
      bus(1'b1, 8'h10, 32'h02);
      begin
        repeat (2) @(posedge hclk);
        ev[1] <= 1'b1;
        @(posedge hclk);
        ev[1] <= 1'b0;
      end
    join
    rd(8'h10, 32'h02);
    bus(1'b1, 8'h0c, 32'hff);
    rd(8'h0c, 32'h7f);
    chk(assigned_bus_address, 7'h7f);
    ev[7] <= 1'b1;
    @(posedge hclk);
    ev[7] <= 1'b0;
    usb_func_reset <= 1'b1;
    @(posedge hclk);
    usb_func_reset <= 1'b0;
    rd(8'h10, 32'h80);
    rd(8'h14, 32'h80);
    complete_run();
  end
endmodule
